// [verilog/mie_execute.sv]
// Execute unit: sequences and carries out one decoded instruction at a time, in one cycle or two with a dummy cycle; a halt gives no done
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module mie_execute
    import mie_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // Instruction from the decoder
    input  wire mie_instr_t         instr,
    input  wire logic               instValid,
    output logic                    instReady,
    output logic                    instDone,
    output logic [PC_W-1:0]         pc,
    // Data memory
    input  wire logic [7:0]         memRdData,
    output mie_memwr_t              memWr,
    // Hardware stack
    input  wire logic [PC_W-1:0]    stackTop,
    output logic                    stackPush,
    output logic [PC_W-1:0]         stackPushData,
    output logic                    stackPop,
    // Watchdog, clock and interrupt side
    input  wire logic               watchdogTimeout,
    input  wire logic               intPending,
    output logic                    watchdogClear,
    output logic                    sysClkRun,
    output logic                    intServe,
    // Register port
    input  wire logic [1:0]         regAddr,
    input  wire logic [7:0]         regWrData,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [7:0]              regRdData
);

    // Whole state of the unit
    typedef struct packed {
        mie_seq_t         seq;       // Sequencer
        mie_pre_t         preLast;   // Pending pre-clear
        logic [PC_W-1:0]  pc;        // Program counter
        logic [7:0]       acc;       // Accumulator
        logic             carry;     // Carry flag
        logic             auxCarry;  // Auxiliary carry flag
        logic             zero;      // Zero flag
        logic             toutFlag;  // Watchdog timeout flag
        logic             pdownFlag; // Power down flag
        logic             gie;       // Global interrupt enable
        logic             ready;     // Accepting instructions
        logic             done;      // Instruction completed
        mie_memwr_t       memWr;     // Memory write request
        logic             push;      // Stack push
        logic [PC_W-1:0]  pushData;  // Pushed address
        logic             pop;       // Stack pop
        logic             wdClr;     // Watchdog clear pulse
        logic             clkRun;    // System clock enable
        logic             intServe;  // Pending interrupt to take
        logic             dummyInt;  // Interrupt pending after return
        logic [7:0]       rdData;    // Register read data
    } mie_state_t;

    mie_state_t stR;    // Registered state
    mie_state_t stNxt;  // Next state

    // Zero test used by every Z-affecting instruction
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == ZERO_B);
    endfunction : isZero

    // Decimal adjust of a byte; returns carry and byte
    function automatic logic [8:0] decAdjust(input logic [7:0] a, input logic auxIn,
                                             input logic c);
        logic [8:0] sum;
        sum = {1'b0, a};
        if ((a[3:0] > BCD_MAX) || auxIn) begin
            sum = sum + {1'b0, ADJ_LOW};
        end
        if ((a[7:4] > BCD_MAX) || c) begin
            sum = sum + {1'b0, ADJ_HIGH};
        end
        decAdjust = {sum[8] | c | (a[7:4] > BCD_MAX), sum[7:0]};
    endfunction : decAdjust

    // Memory write helper: returns a write request
    function automatic mie_memwr_t wrReq(input logic [MA_W-1:0] a, input logic [7:0] d);
        wrReq.we   = 1'b1;
        wrReq.addr = a;
        wrReq.data = d;
    endfunction : wrReq

    // Next-state logic
    always_comb begin
        logic       take;      // Instruction taken this cycle
        logic       twoCyc;    // Needs a dummy cycle
        logic [8:0] adj;       // Decimal adjust result
        logic [7:0] res;       // Byte result
        stNxt          = stR;
        take           = 1'b0;
        twoCyc         = 1'b0;
        adj            = 9'h000;
        res            = ZERO_B;
        // Pulses default low
        stNxt.done     = 1'b0;
        stNxt.memWr.we = 1'b0;
        stNxt.push     = 1'b0;
        stNxt.pop      = 1'b0;
        stNxt.wdClr    = 1'b0;
        stNxt.intServe = 1'b0;
        stNxt.rdData   = ZERO_B;

        case (stR.seq)
            // Normal execution
            S_RUN: begin
                take = instValid;
            end
            // Second cycle of a two-cycle instruction
            S_DUMMY: begin
                stNxt.seq      = S_RUN;
                stNxt.done     = 1'b1;
                stNxt.intServe = stR.dummyInt;
                stNxt.dummyInt = 1'b0;
            end
            // Powered down: only a wake write resumes
            S_HALT: begin
                if (regWr && (regAddr == REG_CTRL) && regWrData[CTRL_WAKE]) begin
                    stNxt.seq = S_RUN;
                end
            end
            default: begin
                stNxt.seq = S_RUN;
            end
        endcase

        if (take) begin
            stNxt.pc = stR.pc + PC_W'(1);
            // Any instruction but a pre-clear breaks the pair
            if ((instr.op != OP_PRE_FIRST) && (instr.op != OP_PRE_SECOND)) begin
                stNxt.preLast = PRE_NONE;
            end
            case (instr.op)
                OP_CALL: begin
                    stNxt.push     = 1'b1;
                    stNxt.pushData = stR.pc + PC_W'(1);
                    stNxt.pc       = instr.target;
                    twoCyc         = 1'b1;
                end
                OP_JMP: begin
                    stNxt.pc = instr.target;
                    twoCyc   = 1'b1;
                end
                OP_CLR: begin
                    stNxt.memWr = wrReq(instr.mAddr, ZERO_B);
                end
                OP_CLRBIT: begin
                    res              = memRdData;
                    res[instr.bitSel] = 1'b0;
                    stNxt.memWr      = wrReq(instr.mAddr, res);
                end
                OP_WD_CLEAR: begin
                    stNxt.wdClr     = 1'b1;
                    stNxt.toutFlag  = 1'b0;
                    stNxt.pdownFlag = 1'b0;
                end
                OP_PRE_FIRST, OP_PRE_SECOND: begin
                    // Effective only right after the other pre-clear
                    if ((instr.op == OP_PRE_FIRST && stR.preLast == PRE_SECOND) ||
                        (instr.op == OP_PRE_SECOND && stR.preLast == PRE_FIRST)) begin
                        stNxt.wdClr     = 1'b1;
                        stNxt.toutFlag  = 1'b0;
                        stNxt.pdownFlag = 1'b0;
                        stNxt.preLast   = PRE_NONE;
                    end else begin
                        stNxt.preLast = (instr.op == OP_PRE_FIRST) ? PRE_FIRST
                                                                  : PRE_SECOND;
                    end
                end
                OP_COMPL, OP_COMPLA: begin
                    res        = ~memRdData;
                    stNxt.zero = isZero(res);
                    if (instr.op == OP_COMPL) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_DEC_ADJ: begin
                    adj         = decAdjust(stR.acc, stR.auxCarry, stR.carry);
                    stNxt.carry = adj[8];
                    stNxt.memWr = wrReq(instr.mAddr, adj[7:0]);
                end
                OP_DEC, OP_DECA: begin
                    res        = memRdData - ONE_B;
                    stNxt.zero = isZero(res);
                    if (instr.op == OP_DEC) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_INC, OP_INCA: begin
                    res        = memRdData + ONE_B;
                    stNxt.zero = isZero(res);
                    if (instr.op == OP_INC) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_HALT: begin
                    stNxt.wdClr     = 1'b1;
                    stNxt.toutFlag  = 1'b0;
                    stNxt.pdownFlag = 1'b1;
                end
                OP_MOV_AM: begin
                    stNxt.acc = memRdData;
                end
                OP_MOV_AX: begin
                    stNxt.acc = instr.imm;
                end
                OP_MOV_MA: begin
                    stNxt.memWr = wrReq(instr.mAddr, stR.acc);
                end
                OP_OR_AM, OP_OR_M: begin
                    res        = stR.acc | memRdData;
                    stNxt.zero = isZero(res);
                    if (instr.op == OP_OR_M) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_OR_AX: begin
                    res        = stR.acc | instr.imm;
                    stNxt.zero = isZero(res);
                    stNxt.acc  = res;
                end
                OP_RET, OP_RET_AX, OP_IRET: begin
                    stNxt.pop = 1'b1;
                    stNxt.pc  = stackTop;
                    twoCyc    = 1'b1;
                    if (instr.op == OP_RET_AX) begin
                        stNxt.acc = instr.imm;
                    end
                    if (instr.op == OP_IRET) begin
                        stNxt.gie      = 1'b1;
                        stNxt.dummyInt = intPending;
                    end
                end
                OP_ROTL, OP_ROTLA: begin
                    res = {memRdData[6:0], memRdData[7]};
                    if (instr.op == OP_ROTL) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_ROTL_C, OP_ROTL_CA: begin
                    res         = {memRdData[6:0], stR.carry};
                    stNxt.carry = memRdData[7];
                    if (instr.op == OP_ROTL_C) begin
                        stNxt.memWr = wrReq(instr.mAddr, res);
                    end else begin
                        stNxt.acc = res;
                    end
                end
                OP_ROTR: begin
                    res         = {memRdData[0], memRdData[7:1]};
                    stNxt.memWr = wrReq(instr.mAddr, res);
                end
                default: begin
                    // No operation
                end
            endcase
            // A write landing on pc_low_byte redirects the program
            if (stNxt.memWr.we && (stNxt.memWr.addr == PC_LOW_ADDR)) begin
                stNxt.pc[7:0] = stNxt.memWr.data;
                twoCyc        = 1'b1;
            end
            // Sequencer step
            if (instr.op == OP_HALT) begin
                stNxt.seq = S_HALT;
            end else if (twoCyc) begin
                stNxt.seq = S_DUMMY;
            end else begin
                stNxt.done = 1'b1;
            end
        end

        // Timeout event wins over any clear in the same cycle
        if (watchdogTimeout) begin
            stNxt.toutFlag = 1'b1;
        end

        // Register reads answer the cycle after the strobe
        if (regRd) begin
            case (regAddr)
                REG_STATUS: begin
                    stNxt.rdData[ST_CARRY] = stR.carry;
                    stNxt.rdData[ST_AUX]   = stR.auxCarry;
                    stNxt.rdData[ST_ZERO]  = stR.zero;
                    stNxt.rdData[ST_TOUT]  = stR.toutFlag;
                    stNxt.rdData[ST_PDOWN] = stR.pdownFlag;
                    stNxt.rdData[ST_GIE]   = stR.gie;
                    stNxt.rdData[ST_HALT]  = (stR.seq == S_HALT);
                end
                REG_ACC: begin
                    stNxt.rdData = stR.acc;
                end
                default: begin
                    stNxt.rdData = ZERO_B;
                end
            endcase
        end

        stNxt.ready  = (stNxt.seq == S_RUN);
        stNxt.clkRun = (stNxt.seq != S_HALT);
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stR        <= '0;
            stR.seq    <= S_RUN;
            stR.ready  <= 1'b1;
            stR.clkRun <= 1'b1;
        end else begin
            stR <= stNxt;
        end
    end

    // Outputs straight from the state register
    assign instReady     = stR.ready;
    assign instDone      = stR.done;
    assign pc            = stR.pc;
    assign memWr         = stR.memWr;
    assign stackPush     = stR.push;
    assign stackPushData = stR.pushData;
    assign stackPop      = stR.pop;
    assign watchdogClear = stR.wdClr;
    assign sysClkRun     = stR.clkRun;
    assign intServe      = stR.intServe;
    assign regRdData     = stR.rdData;

    // Checks
    wire logic tk = instValid && stR.ready;  // Instruction taken

    call_push_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_CALL |=> stackPush && stackPushData == $past(stR.pc) + 11'h001
            && pc == $past(instr.target) && !instDone ##1 instDone)
        else $error("call did not push return address");
    jump_two_cyc_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_JMP |=> !instReady && $stable(stR.zero) ##1 instDone)
        else $error("jump not two cycles");
    clear_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_CLR |=> memWr.we && memWr.data == 8'h00)
        else $error("clear wrote nonzero");
    pre_alone_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_PRE_FIRST && stR.preLast != PRE_SECOND |=> !watchdogClear)
        else $error("lone pre-clear took effect");
    pre_pair_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_PRE_SECOND && stR.preLast == PRE_FIRST && !watchdogTimeout
        |=> watchdogClear && !stR.toutFlag && !stR.pdownFlag)
        else $error("pre-clear pair did not clear flags");
    halt_stop_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_HALT |=> !sysClkRun && stR.pdownFlag && watchdogClear
            && !instReady)
        else $error("power down not entered");
    ret_pop_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_RET |=> stackPop && pc == $past(stackTop) ##1 instDone)
        else $error("return did not pop");
    iret_enable_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_IRET |=> stR.gie && stackPop)
        else $error("interrupt return left interrupts off");
    one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_NOP |=> instDone && instReady && pc == $past(stR.pc) + 11'h001)
        else $error("no-operation not single cycle");
    rotl_carry_a: assert property (@(posedge core_clk) disable iff (rst)
        tk && instr.op == OP_ROTL_CA |=> stR.carry == $past(memRdData[7])
            && stR.acc == {$past(memRdData[6:0]), $past(stR.carry)})
        else $error("rotate through carry wrong");
endmodule : mie_execute

// [inc/mie_pkg.sv]
// Package: opcodes, state types, offsets and constants of the execute unit
package mie_pkg;
    localparam int PC_W       = 11;        // Program counter width
    localparam int MA_W       = 7;         // Data memory address width
    localparam logic [MA_W-1:0] PC_LOW_ADDR = 7'h06; // Data address of pc_low_byte
    localparam logic [3:0] BCD_MAX = 4'h9; // Largest decimal digit
    localparam logic [7:0] ADJ_LOW  = 8'h06; // Low nibble correction
    localparam logic [7:0] ADJ_HIGH = 8'h60; // High nibble correction
    localparam logic [7:0] ZERO_B   = 8'h00; // Cleared byte
    localparam logic [7:0] ONE_B    = 8'h01; // Unit step
    // Register port offsets
    localparam logic [1:0] REG_STATUS = 2'h0; // Flags and run state
    localparam logic [1:0] REG_ACC    = 2'h1; // Accumulator
    localparam logic [1:0] REG_CTRL   = 2'h2; // Control, write only
    localparam int CTRL_WAKE  = 0;         // Write 1: leave power down
    // Status bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_AUX   = 1;
    localparam int ST_ZERO  = 2;
    localparam int ST_TOUT  = 3;
    localparam int ST_PDOWN = 4;
    localparam int ST_GIE   = 5;
    localparam int ST_HALT  = 6;

    // Instruction kinds handed over by the decoder
    typedef enum logic [4:0] {
        OP_NOP, OP_CALL, OP_JMP, OP_CLR, OP_CLRBIT, OP_WD_CLEAR, OP_PRE_FIRST,
        OP_PRE_SECOND, OP_COMPL, OP_COMPLA, OP_DEC_ADJ, OP_DEC, OP_DECA,
        OP_INC, OP_INCA, OP_HALT, OP_MOV_AM, OP_MOV_AX, OP_MOV_MA, OP_OR_AM,
        OP_OR_AX, OP_OR_M, OP_RET, OP_RET_AX, OP_IRET, OP_ROTL, OP_ROTLA,
        OP_ROTL_C, OP_ROTL_CA, OP_ROTR
    } mie_op_t;

    // One decoded instruction with its operand
    typedef struct packed {
        mie_op_t          op;      // Instruction kind
        logic [PC_W-1:0]  target;  // Branch target
        logic [MA_W-1:0]  mAddr;   // Data memory address
        logic [7:0]       imm;     // Immediate byte
        logic [2:0]       bitSel;  // Bit index for bit clear
    } mie_instr_t;

    // Sequencer states
    typedef enum logic [1:0] {S_RUN, S_DUMMY, S_HALT} mie_seq_t;
    // Last pre-clear seen
    typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} mie_pre_t;

    // Data memory write request
    typedef struct packed {
        logic            we;
        logic [MA_W-1:0] addr;
        logic [7:0]      data;
    } mie_memwr_t;
endpackage : mie_pkg

// [tb/mie_partner.sv]
// Partner model: data memory and hardware stack beside the execute unit
`timescale 1ns/1ps
module mie_partner
    import mie_pkg::*;
(
    // Clock
    input  wire logic            core_clk,
    // Data memory side
    input  wire logic [MA_W-1:0] mAddr,
    input  wire mie_memwr_t      memWr,
    output logic [7:0]           memRdData,
    // Stack side
    input  wire logic            stackPush,
    input  wire logic [PC_W-1:0] stackPushData,
    input  wire logic            stackPop,
    output logic [PC_W-1:0]      stackTop
);
    logic [7:0]      mem [128]; // Data memory image
    logic [PC_W-1:0] stk [8];   // Stack entries
    int              sp = 0;    // Stack depth
    // Read port follows the address at once
    assign memRdData = mem[mAddr];
    // An empty stack shows no stale entry
    assign stackTop = (sp > 0) ? stk[sp-1] : ~stackPushData;
    // Stores and stack moves land at the edge
    always @(posedge core_clk) begin
        if (memWr.we)
            mem[memWr.addr] <= memWr.data;
        if (stackPush) begin
            stk[sp] <= stackPushData;
            sp <= sp + 1;
        end else if (stackPop && sp > 0)
            sp <= sp - 1;
    end
endmodule : mie_partner

// [tb/tb_mcu_instruction_execute.sv]
// Testbench: random and corner instruction runs on the execute unit
`timescale 1ns/1ps
module tb_mcu_instruction_execute
    import mie_pkg::*;
;
    logic core_clk = 0, rst = 1, instValid = 0, regWr = 0, regRd = 0;
    logic watchdogTimeout = 0, intPending = 0;
    logic [1:0] regAddr = '0;
    logic [7:0] regWrData = '0, x, v, r, st;
    mie_instr_t instr = '0;
    wire logic instReady, instDone, stackPush, stackPop, watchdogClear, sysClkRun, intServe;
    wire logic [PC_W-1:0] pc, stackPushData, stackTop;
    wire logic [7:0] memRdData, regRdData;
    wire mie_memwr_t memWr;
    int nErrors = 0, testsRun = 0, cyc, nServe = 0, nClr = 0;
    logic [PC_W-1:0] p;
    logic [8:0] e;
    logic [6:0] a;
    mie_op_t o;
    mie_op_t ops[18] = '{OP_CLR, OP_CLRBIT, OP_COMPL, OP_COMPLA, OP_DEC, OP_DECA, OP_INC,
        OP_INCA, OP_ROTL, OP_ROTLA, OP_ROTL_C, OP_ROTL_CA, OP_ROTR, OP_OR_AM, OP_OR_M,
        OP_MOV_AM, OP_MOV_MA, OP_DEC_ADJ};
    mie_op_t rets[3] = '{OP_RET, OP_RET_AX, OP_IRET};
    mie_execute u_dut (.core_clk, .rst, .instr, .instValid, .instReady, .instDone, .pc,
        .memRdData, .memWr, .stackTop, .stackPush, .stackPushData, .stackPop, .watchdogTimeout,
        .intPending, .watchdogClear, .sysClkRun, .intServe, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData);
    mie_partner u_mem (.core_clk, .mAddr(instr.mAddr), .memWr, .memRdData, .stackPush,
        .stackPushData, .stackPop, .stackTop);
    // Clock and pulse counters
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (intServe === 1'b1) nServe++;
    always @(posedge core_clk) if (watchdogClear === 1'b1) nClr++;
    // Compare and count
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Offer one instruction, hold it until taken, count cycles to completion
    task automatic exe(input mie_op_t op, input logic [6:0] ad, input logic [7:0] im,
                       input logic [10:0] t);
        logic rdy;
        @(posedge core_clk);
        instr <= '{op, t, ad, im, im[2:0]};
        instValid <= 1'b1;
        do begin
            @(negedge core_clk);
            rdy = instReady;
            @(posedge core_clk);
        end while (rdy !== 1'b1);
        instValid <= 1'b0;
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
        end while (instDone !== 1'b1 && cyc < 4);
    endtask : exe
    // Register port read and write
    task automatic rd(input logic [1:0] ad, output logic [7:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        d = regRdData;
    endtask : rd
    task automatic wr(input logic [1:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    // Timeout flag pulse from the watchdog
    task automatic tout();
        @(posedge core_clk);
        watchdogTimeout <= 1'b1;
        @(posedge core_clk);
        watchdogTimeout <= 1'b0;
    endtask : tout
    // Expected {carry, result} of a data operation
    function automatic logic [8:0] calc(mie_op_t op, logic [7:0] m, logic [7:0] av,
                                        logic [7:0] s0);
        logic [8:0] s;
        logic       c;
        c = s0[ST_CARRY];
        s = {1'b0, av} + (((av[3:0] > 4'h9) || s0[ST_AUX]) ? 9'h006 : 9'h000);
        s = s + (((av[7:4] > 4'h9) || c) ? 9'h060 : 9'h000);
        case (op)
            OP_CLR: return {c, 8'h00};
            OP_CLRBIT: return {c, m & ~(8'h01 << av[2:0])};
            OP_COMPL, OP_COMPLA: return {c, ~m};
            OP_DEC, OP_DECA: return {c, m - 8'h01};
            OP_INC, OP_INCA: return {c, m + 8'h01};
            OP_ROTL, OP_ROTLA: return {c, m[6:0], m[7]};
            OP_ROTL_C, OP_ROTL_CA: return {m[7], m[6:0], c};
            OP_ROTR: return {c, m[0], m[7:1]};
            OP_OR_AM, OP_OR_M: return {c, av | m};
            OP_MOV_AM: return {c, m};
            OP_DEC_ADJ: return {c | s[8] | (av[7:4] > 4'h9), s[7:0]};
            default: return {c, av};
        endcase
    endfunction : calc
    // Verdict
    task automatic endOfTest();
        $display("compares %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : endOfTest
    // Hang guard
    initial begin
        #400us;
        nErrors++;
        endOfTest();
    end
    // Main sequence
    initial begin
        void'($urandom(32'habc7));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 72; k++) begin
            o = ops[k % 18];
            a = 7'($urandom_range(8, 127));
            v = (k < 18) ? 8'h00 : ((k < 36) ? 8'hFF : 8'($urandom));
            x = (k < 36) ? 8'h80 : 8'($urandom);
            if (o == OP_DEC_ADJ && x[7:4] == 4'h9)
                x[7:4] = 4'h5;
            u_mem.mem[a] = v;
            exe(OP_MOV_AX, 7'h00, x, 11'h000);
            rd(REG_STATUS, st);
            e = calc(o, v, x, st);
            exe(o, a, x, 11'h000);
            chk(11'(cyc), 11'd1);
            rd(REG_ACC, r);
            chk((o inside {OP_COMPLA, OP_DECA, OP_INCA, OP_ROTLA, OP_ROTL_CA, OP_OR_AM,
                OP_MOV_AM}) ? r : u_mem.mem[a], e[7:0]);
            rd(REG_STATUS, r);
            chk(r, (o inside {OP_COMPL, OP_COMPLA, OP_DEC, OP_DECA, OP_INC, OP_INCA, OP_OR_AM,
                OP_OR_M}) ? {st[7:3], e[7:0] == 8'h00, st[1], e[8]} : {st[7:1], e[8]});
        end
        exe(OP_OR_AX, 7'h00, 8'h0A, 11'h000);
        rd(REG_ACC, r);
        chk(r, x | 8'h0A);
        exe(OP_JMP, 7'h00, 8'h00, 11'h123);
        chk(pc, 11'h123);
        chk(11'(cyc), 11'd2);
        @(posedge core_clk);
        intPending <= 1'b1;
        foreach (rets[i]) begin
            p = pc;
            exe(OP_CALL, 7'h00, 8'h00, 11'h2F0);
            chk(u_mem.stk[0], p + 11'h001);
            exe(rets[i], 7'h00, 8'h3C, 11'h000);
            chk(pc, p + 11'h001);
            chk(11'(cyc), 11'd2);
        end
        rd(REG_ACC, r);
        chk(r, 8'h3C);
        rd(REG_STATUS, r);
        chk({r[ST_GIE], 7'(nServe)}, 8'h81);
        exe(OP_MOV_MA, PC_LOW_ADDR, 8'h00, 11'h000);
        chk(11'(cyc), 11'd2);
        tout();
        exe(OP_PRE_FIRST, 7'h00, 8'h00, 11'h000);
        exe(OP_PRE_FIRST, 7'h00, 8'h00, 11'h000);
        rd(REG_STATUS, r);
        chk(r[ST_TOUT], 1'b1);
        exe(OP_PRE_SECOND, 7'h00, 8'h00, 11'h000);
        rd(REG_STATUS, r);
        chk(r[ST_TOUT], 1'b0);
        tout();
        exe(OP_HALT, 7'h00, 8'h00, 11'h000);
        rd(REG_STATUS, r);
        chk({r[ST_PDOWN], r[ST_TOUT], sysClkRun, 8'(cyc)}, 11'h404);
        wr(REG_CTRL, 8'h01);
        p = pc;
        exe(OP_NOP, 7'h00, 8'h00, 11'h000);
        chk(pc, p + 11'h001);
        tout();
        exe(OP_WD_CLEAR, 7'h00, 8'h00, 11'h000);
        rd(REG_STATUS, r);
        chk({r[ST_PDOWN], r[ST_TOUT]}, 2'h0);
        tout();
        exe(OP_PRE_SECOND, 7'h00, 8'h00, 11'h000);
        exe(OP_PRE_FIRST, 7'h00, 8'h00, 11'h000);
        rd(REG_STATUS, r);
        chk(r[ST_TOUT], 1'b0);
        chk(11'(nClr), 11'h004);
        rd(2'h3, r);
        chk(r, 8'h00);
        endOfTest();
    end
endmodule : tb_mcu_instruction_execute
